//--- design/fqb_pkg.sv
// Constants and types for the QPI read parameter and block lock interpreter
//Behaviour
// - Set read parameters accepted only in QPI
// - Dummy select picks 2, 4, 6 or 8
// - Wrap select picks 8, 16, 32 or 64
// - Programmed dummy count applies only in QPI
// - Defaults: wrap 8 bytes, dummy 2 clocks
// - SPI wrap field sets wrap, kept across switch
// - Burst read wraps inside aligned window
// - One mode at a time; enter only via 38h
// - Power-up starts in SPI mode
// - Enter QPI ignored unless quad enable set
// - Exit QPI returns to SPI mode
// - Mode switch keeps latch, suspend, wrap
// - Lock bits protect only when select set
// - Lock bits volatile, all ones after reset
// - Lock opcode plus address sets bit if enabled
// - Unlock opcode plus address clears bit if enabled
// - Read lock shifts value out MSB first
// - Global lock sets all bits if enabled
// - Global unlock clears all bits if enabled
// - Opcode bits sampled on rising serial clock
// - Reset instruction restores read parameter defaults
package fqb_pkg;
	// Opcodes
	localparam logic [7:0] OP_SET_READ_PARAM = 8'hC0;
	localparam logic [7:0] OP_ENTER_QPI = 8'h38;
	localparam logic [7:0] OP_EXIT_QPI = 8'hFF;
	localparam logic [7:0] OP_LOCK = 8'h36;
	localparam logic [7:0] OP_UNLOCK = 8'h39;
	localparam logic [7:0] OP_READ_LOCK = 8'h3D;
	localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
	localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
	// Frame lengths in bits
	localparam logic [7:0] LEN_OPCODE = 8'h08;
	localparam logic [7:0] LEN_PARAM = 8'h10;
	localparam logic [7:0] LEN_ADDR = 8'h20;
	// Serial clock edges up to the end of the address
	localparam logic [5:0] EDGE_ADDR_SPI = 6'h20;
	localparam logic [5:0] EDGE_ADDR_QPI = 6'h08;
	localparam logic [5:0] CNT_SAT = 6'h3F;
	// Read parameter byte fields and defaults
	localparam int DUMMY_SEL_LSB = 4;
	localparam int WRAP_SEL_LSB = 0;
	localparam logic [7:0] PARAM_RST = 8'h00;
	localparam logic [1:0] WRAP_SEL_RST = 2'h0;
	localparam logic [3:0] DUMMY_BASE = 4'h2;
	localparam logic [3:0] SPI_FAST_DUMMY = 4'h8;
	localparam logic [6:0] WRAP_BASE = 7'h08;
	// Lock array
	localparam int LOCK_BITS = 256;
	localparam int LOCK_IDX_LSB = 16;
	localparam logic LOCK_RST = 1'b1;
	// Output lanes while returning the lock value
	localparam logic [3:0] OE_SPI = 4'h2;
	localparam logic [3:0] OE_QPI = 4'hF;
	localparam logic [2:0] LAST_BIT_IDX = 3'h7;
	// Command mode
	typedef enum logic {FQB_SPI = 1'b0, FQB_QPI = 1'b1} fqb_mode_t;
	// Link side capture, stable once the frame has ended
	typedef struct packed {
		logic tog;
		logic [5:0] cnt;
		logic [31:0] spi_sh;
		logic [31:0] qpi_sh;
	} fqb_link_t;
	// Data lanes driven back to the host
	typedef struct packed {
		logic [3:0] dout;
		logic [3:0] oe;
	} fqb_pad_t;
endpackage

//--- design/fqb_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module fqb_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_r; // First stage, read only by the second
	logic sync_r; // Second stage

	// Two stages on the system clock
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;
endmodule

//--- design/fqb_cmd.sv
// QPI read parameter, mode switch and block lock command interpreter
`timescale 1ns/1ps
module fqb_cmd import fqb_pkg::*; (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe_o,
	input wire logic quad_enable_bit_i,
	input wire logic write_enable_latch_i,
	input wire logic write_protect_select_i,
	input wire logic block_protect_hit_i,
	input wire logic dev_reset_i,
	input wire logic spi_wrap_set_i,
	input wire logic [1:0] spi_wrap_field_i,
	input wire logic burst_load_i,
	input wire logic burst_step_i,
	input wire logic [23:0] burst_addr_i,
	input wire logic [23:0] prot_addr_i,
	output logic qpi_mode_o,
	output logic [7:0] read_parameter_byte_o,
	output logic [3:0] dummy_clocks_o,
	output logic [6:0] wrap_bytes_o,
	output logic [23:0] burst_addr_o,
	output logic array_protect_o
);
	// Link domain state
	fqb_link_t link_r; // Capture of the current or last frame
	fqb_link_t link_nxt; // Next capture
	logic started_r; // Frame has seen its first rising edge
	fqb_pad_t pad_r; // Driven lanes
	fqb_pad_t pad_nxt;
	logic [2:0] idx_r; // Bit slot of the returned byte
	logic rd_on_r; // Lock value is being returned
	logic rd_bit_r; // Lock value held for the frame
	// System domain state
	fqb_mode_t mode_r; // Current command mode
	fqb_mode_t mode_nxt;
	logic cs_s; // Synchronised chip select
	logic cs_d_r; // Delayed chip select
	logic seen_tog_r; // Last frame already handled
	logic [7:0] param_r; // Read parameter byte
	logic [1:0] wrap_sel_r; // Wrap select, shared by both modes, untouched by mode switches
	logic [LOCK_BITS-1:0] lock_r; // Block lock bits
	logic [LOCK_BITS-1:0] lock_nxt;
	logic [23:0] burst_r; // Burst read address
	logic [23:0] burst_nxt;
	logic prot_r; // Protection of the probed address

	// Mode seen by both domains; it only changes between frames
	wire qpi_w = (mode_r == FQB_QPI);

	// Rising edge capture: one bit or one nibble per clock
	always_comb begin
		link_nxt = link_r;
		link_nxt.spi_sh = {link_r.spi_sh[30:0], io_i[0]};
		link_nxt.qpi_sh = {link_r.qpi_sh[27:0], io_i};
		if (!started_r) begin
			link_nxt.tog = ~link_r.tog;
			link_nxt.cnt = 6'h01;
		end else if (link_r.cnt != CNT_SAT) begin
			link_nxt.cnt = link_r.cnt + 6'h01;
		end
	end

	// Capture registers keep their value after the frame
	always_ff @(posedge sclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			link_r <= '0;
		end else begin
			link_r <= link_nxt;
		end
	end

	// Frame start marker, cleared while chip select is high
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			started_r <= 1'b0;
		end else begin
			started_r <= 1'b1;
		end
	end

	// Read lock starts once opcode and address are in
	wire [5:0] edge_addr_w = qpi_w ? EDGE_ADDR_QPI : EDGE_ADDR_SPI;
	wire [31:0] live_w = qpi_w ? link_r.qpi_sh : link_r.spi_sh;
	wire rd_go_w = started_r && (link_r.cnt == edge_addr_w)
		&& (live_w[31:24] == OP_READ_LOCK);
	wire [7:0] live_idx_w = live_w[LOCK_IDX_LSB+7:LOCK_IDX_LSB];
	wire rd_bit_w = rd_go_w ? lock_r[live_idx_w] : rd_bit_r;
	wire rd_act_w = rd_go_w || rd_on_r;
	// Byte is seven zeros then the lock bit, MSB first
	wire spi_bit_w = (idx_r == LAST_BIT_IDX) && rd_bit_w;
	wire qpi_bit_w = idx_r[0] && rd_bit_w;

	// Falling edge output lanes
	always_comb begin
		pad_nxt = '0;
		if (rd_act_w) begin
			if (qpi_w) begin
				pad_nxt.dout = {3'h0, qpi_bit_w};
				pad_nxt.oe = OE_QPI;
			end else begin
				pad_nxt.dout = {2'h0, spi_bit_w, 1'b0};
				pad_nxt.oe = OE_SPI;
			end
		end
	end

	// Output shifts on falling edges, released when the frame ends
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			pad_r <= '0;
			idx_r <= 3'h0;
			rd_on_r <= 1'b0;
			rd_bit_r <= 1'b0;
		end else begin
			pad_r <= pad_nxt;
			idx_r <= rd_act_w ? idx_r + 3'h1 : idx_r;
			rd_on_r <= rd_act_w;
			rd_bit_r <= rd_bit_w;
		end
	end

	assign io_o = pad_r.dout;
	assign io_oe_o = pad_r.oe;

	// Chip select into the system domain
	fqb_sync #(.RST_VAL(1'b1)) u_cs_sync (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.d_i(cs_n_i),
		.q_o(cs_s)
	);

	// Frame end detect and command fields
	wire frame_end_w = cs_s && !cs_d_r;
	wire exec_w = frame_end_w && (link_r.tog != seen_tog_r);
	wire [7:0] len_w = qpi_w ? {link_r.cnt, 2'h0} : {2'h0, link_r.cnt};
	wire [31:0] word_w = qpi_w ? link_r.qpi_sh : link_r.spi_sh;
	wire is_op_w = (len_w == LEN_OPCODE);
	wire is_par_w = (len_w == LEN_PARAM);
	wire is_adr_w = (len_w == LEN_ADDR);
	wire [7:0] op_w = is_adr_w ? word_w[31:24] : is_par_w ? word_w[15:8] : word_w[7:0];
	wire [7:0] lk_idx_w = word_w[LOCK_IDX_LSB+7:LOCK_IDX_LSB];
	wire wr_ok_w = exec_w && write_enable_latch_i;

	// Command decode
	wire go_qpi_w = exec_w && !qpi_w && is_op_w && (op_w == OP_ENTER_QPI)
		&& quad_enable_bit_i;
	wire go_spi_w = exec_w && qpi_w && is_op_w && (op_w == OP_EXIT_QPI);
	wire set_par_w = exec_w && qpi_w && is_par_w && (op_w == OP_SET_READ_PARAM);
	wire lk_w = wr_ok_w && is_adr_w && (op_w == OP_LOCK);
	wire ulk_w = wr_ok_w && is_adr_w && (op_w == OP_UNLOCK);
	wire glk_w = wr_ok_w && is_op_w && (op_w == OP_GLOBAL_LOCK);
	wire gulk_w = wr_ok_w && is_op_w && (op_w == OP_GLOBAL_UNLOCK);

	// Mode machine
	always_comb begin
		case (mode_r)
			FQB_SPI: mode_nxt = go_qpi_w ? FQB_QPI : FQB_SPI;
			FQB_QPI: mode_nxt = go_spi_w ? FQB_SPI : FQB_QPI;
			default: mode_nxt = FQB_SPI;
		endcase
		if (dev_reset_i) begin
			mode_nxt = FQB_SPI;
		end
	end

	// Per-bit lock update, reset and global take priority
	genvar gi;
	generate
		for (gi = 0; gi < LOCK_BITS; gi++) begin : g_lock
			wire hit_w = (lk_idx_w == 8'(gi));
			assign lock_nxt[gi] = dev_reset_i ? LOCK_RST :
				glk_w ? 1'b1 :
				gulk_w ? 1'b0 :
				(lk_w && hit_w) ? 1'b1 :
				(ulk_w && hit_w) ? 1'b0 :
				lock_r[gi];
		end
	endgenerate

	// Wrap window inside the aligned block
	wire [23:0] mask_w = {17'h0, wrap_bytes_o - 7'h01};
	wire [23:0] inc_w = burst_r + 24'h1;
	always_comb begin
		burst_nxt = burst_r;
		if (burst_load_i) begin
			burst_nxt = burst_addr_i;
		end else if (burst_step_i) begin
			burst_nxt = (burst_r & ~mask_w) | (inc_w & mask_w);
		end
	end

	// Mode, frame tracking and lock bits
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_r <= FQB_SPI;
			cs_d_r <= 1'b1;
			seen_tog_r <= 1'b0;
			lock_r <= '1;
		end else begin
			mode_r <= mode_nxt;
			cs_d_r <= cs_s;
			seen_tog_r <= frame_end_w ? link_r.tog : seen_tog_r;
			lock_r <= lock_nxt;
		end
	end

	// Read parameter byte and wrap select
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			param_r <= PARAM_RST;
			wrap_sel_r <= WRAP_SEL_RST;
		end else if (dev_reset_i) begin
			param_r <= PARAM_RST;
			wrap_sel_r <= WRAP_SEL_RST;
		end else if (set_par_w) begin
			param_r <= word_w[7:0];
			wrap_sel_r <= word_w[WRAP_SEL_LSB+1:WRAP_SEL_LSB];
		end else if (spi_wrap_set_i && !qpi_w) begin
			wrap_sel_r <= spi_wrap_field_i;
		end
	end

	// Burst address and protection result
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			burst_r <= 24'h0;
			prot_r <= 1'b1;
		end else begin
			burst_r <= burst_nxt;
			prot_r <= write_protect_select_i ?
				lock_r[prot_addr_i[LOCK_IDX_LSB+7:LOCK_IDX_LSB]] : block_protect_hit_i;
		end
	end

	// Settings seen by the read engines
	wire [1:0] dsel_w = param_r[DUMMY_SEL_LSB+1:DUMMY_SEL_LSB];
	assign dummy_clocks_o = qpi_w ? DUMMY_BASE + {1'b0, dsel_w, 1'b0} : SPI_FAST_DUMMY;
	assign wrap_bytes_o = WRAP_BASE << wrap_sel_r;
	assign qpi_mode_o = qpi_w;
	assign read_parameter_byte_o = param_r;
	assign burst_addr_o = burst_r;
	assign array_protect_o = prot_r;

	// Checks on the system clock
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	// Power-on state, seen at the first edge after release
	a_power_defaults: assert property (
		$rose(rstn_i) |-> &lock_r && !qpi_mode_o && wrap_bytes_o == WRAP_BASE
		&& read_parameter_byte_o == PARAM_RST)
		else $error("Power-on defaults wrong");

	// Mode switching
	a_qpi_entry_gate: assert property (
		$rose(qpi_mode_o) |-> $past(exec_w && quad_enable_bit_i && !dev_reset_i))
		else $error("QPI entered without quad enable");
	a_qpi_entry_taken: assert property (
		go_qpi_w && !dev_reset_i |=> qpi_mode_o)
		else $error("Enter QPI was not taken");
	a_qpi_exit_op: assert property (
		go_spi_w && !dev_reset_i |=> !qpi_mode_o)
		else $error("Exit QPI did not return to SPI");
	a_mode_keeps_wrap: assert property (
		$changed(qpi_mode_o) && !$past(dev_reset_i) |-> $stable(wrap_sel_r))
		else $error("Mode switch changed wrap length");

	// Read parameters and the settings derived from them
	a_param_spi_reject: assert property (
		exec_w && !qpi_w && !dev_reset_i |=> $stable(read_parameter_byte_o))
		else $error("Read parameters changed in SPI mode");
	a_param_load: assert property (
		set_par_w && !dev_reset_i |=> read_parameter_byte_o == $past(word_w[7:0]))
		else $error("Read parameter byte not loaded");
	a_dummy_map: assert property (
		qpi_mode_o |-> dummy_clocks_o == 4'(2 + 2 * dsel_w))
		else $error("Dummy clock count mismatch");
	a_spi_dummy_fixed: assert property (
		!qpi_mode_o |-> dummy_clocks_o == SPI_FAST_DUMMY)
		else $error("SPI dummy count not fixed");
	a_wrap_map: assert property (
		wrap_bytes_o == 7'(8 << wrap_sel_r))
		else $error("Wrap length mismatch");
	a_spi_wrap_load: assert property (
		spi_wrap_set_i && !qpi_w && !dev_reset_i |=> wrap_sel_r == $past(spi_wrap_field_i))
		else $error("SPI wrap field not taken");
	a_reset_defaults: assert property (
		dev_reset_i |=> wrap_bytes_o == WRAP_BASE && read_parameter_byte_o == PARAM_RST
		&& !qpi_mode_o && &lock_r)
		else $error("Reset did not restore defaults");

	// Lock bits
	a_lock_needs_wel: assert property (
		!$stable(lock_r) |-> $past(dev_reset_i || (exec_w && write_enable_latch_i)))
		else $error("Lock bits changed without write enable");
	a_lock_one_set: assert property (
		lk_w && !dev_reset_i |=> lock_r[$past(lk_idx_w)])
		else $error("Addressed lock bit not set");
	a_lock_one_only: assert property (
		(lk_w || ulk_w) && !dev_reset_i |=> $countones(lock_r ^ $past(lock_r)) <= 1)
		else $error("Single lock command touched other bits");
	a_unlock_one_clear: assert property (
		ulk_w && !dev_reset_i |=> !lock_r[$past(lk_idx_w)])
		else $error("Addressed lock bit not cleared");
	a_global_set: assert property (
		glk_w && !dev_reset_i |=> &lock_r)
		else $error("Global lock left a bit clear");
	a_global_clear: assert property (
		gulk_w && !dev_reset_i |=> ~|lock_r)
		else $error("Global unlock left a bit set");

	// Burst address
	a_burst_load: assert property (
		burst_load_i |=> burst_addr_o == $past(burst_addr_i))
		else $error("Burst start address not loaded");
	a_burst_step: assert property (
		burst_step_i && !burst_load_i |=>
		(burst_addr_o & $past(mask_w)) == (($past(burst_addr_o) + 24'h1) & $past(mask_w)))
		else $error("Burst did not advance inside its window");
	a_burst_window: assert property (
		burst_step_i && !burst_load_i |=> (burst_addr_o & ~$past(mask_w)) == ($past(burst_r) & ~$past(mask_w)))
		else $error("Burst left its wrap window");

	// Protection source and output lanes
	a_protect_source: assert property (
		!write_protect_select_i |=> array_protect_o == $past(block_protect_hit_i))
		else $error("Protection source wrong");
	a_lanes_idle: assert property (
		cs_n_i |-> io_oe_o == 4'h0)
		else $error("Lanes driven outside a frame");
	a_spi_lane_one: assert property (
		!qpi_mode_o |-> io_oe_o == 4'h0 || io_oe_o == OE_SPI)
		else $error("Wrong lanes driven in SPI mode");

	// Main scenarios reached
	c_enter_qpi: cover property ($rose(qpi_mode_o));
	c_exit_qpi: cover property (go_spi_w);
	c_set_param: cover property (set_par_w);
	c_global_unlock: cover property (gulk_w ##1 ~|lock_r);
	c_lock_one: cover property (lk_w);
endmodule

//--- test/fqb_host.sv
// Host controller model driving the serial link
`timescale 1ns/1ps
module fqb_host (
	input wire logic [3:0] line_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic [3:0] io_o
);
	// Clock stopped low and select high outside frames
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		io_o = 4'h0;
	end
	// One frame; a unit is a bit in SPI and a nibble in QPI
	task frame(input logic q, input logic [31:0] d, input int n, input int rd, output logic [7:0] r);
		int i;
		r = 8'h00;
		cs_n_o = 1'b0;
		for (i = 0; i < n + rd; i++) begin
			if (i < n) begin
				io_o = q ? d[31 - 4 * i -: 4] : {~io_o[3:1], d[31 - i]};
			end else begin
				io_o = ~io_o; // Released lanes keep no stale value
			end
			#32 sclk_o = 1'b1;
			if (i >= n) begin
				r = q ? {r[3:0], line_i} : {r[6:0], line_i[1]};
			end
			#32 sclk_o = 1'b0;
		end
		#32 cs_n_o = 1'b1;
		io_o = ~io_o;
		#400;
	endtask
endmodule

//--- test/fqb_cmd_tb.sv
// Testbench for the QPI parameter, mode and lock interpreter
`timescale 1ns/1ps
module fqb_cmd_tb;
	import fqb_pkg::*;
	logic clk_i, rstn_i, qe, write_enable_latch, write_protect_select, hit, dev_rst, wset, bload, bstep, qm, sclk, cs_n, qpi, aprot;
	logic [1:0] wfld;
	logic [23:0] baddr, bout;
	logic [3:0] dout, doe, hio, io_w, dummy, k;
	logic [6:0] wrap;
	logic [7:0] pbyte, rb;
	int err_total, tests_run, i;
	// Wire level from device and host drivers
	assign io_w = (doe & dout) | (~doe & hio);
	fqb_cmd uut (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_w), .io_o(dout),
		.io_oe_o(doe), .quad_enable_bit_i(qe), .write_enable_latch_i(write_enable_latch), .write_protect_select_i(write_protect_select),
		.block_protect_hit_i(hit), .dev_reset_i(dev_rst), .spi_wrap_set_i(wset), .spi_wrap_field_i(wfld),
		.burst_load_i(bload), .burst_step_i(bstep), .burst_addr_i(baddr), .prot_addr_i(24'h050000),
		.qpi_mode_o(qpi), .read_parameter_byte_o(pbyte), .dummy_clocks_o(dummy), .wrap_bytes_o(wrap),
		.burst_addr_o(bout), .array_protect_o(aprot));
	fqb_host host (.line_i(io_w), .sclk_o(sclk), .cs_n_o(cs_n), .io_o(hio));
	// Compare and count
	task chk(input logic [23:0] g, input logic [23:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task report_and_stop;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Frame in the current mode, counts given in bits
	task cmd(input logic [31:0] d, input int bits, input int rd);
		host.frame(qm, d, qm ? bits / 4 : bits, qm ? rd / 4 : rd, rb);
	endtask
	task rdlock(input logic [23:0] a, input logic [7:0] e);
		cmd({OP_READ_LOCK, a}, 32, 8);
		chk(rb, e);
	endtask
	// System clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// Hang guard
	initial begin
		#3000000;
		err_total++;
		report_and_stop;
	end
	initial begin
		{err_total, tests_run, qm} = 0;
		{rstn_i, qe, write_enable_latch, dev_rst, wset, bload, bstep, wfld, baddr} = 0;
		{write_protect_select, hit} = 2'h3;
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(qpi, 24'h0);
		chk(pbyte, 24'h0);
		chk(wrap, 24'h8);
		chk(dummy, 24'h8);
		chk(aprot, 24'h1);
		cmd({OP_SET_READ_PARAM, 8'h31, 16'h0}, 16, 0);
		chk(pbyte, 24'h0);
		cmd({OP_ENTER_QPI, 24'h0}, 8, 0);
		chk(qpi, 24'h0);
		$display("Test defaults done");
		@(posedge clk_i);
		qe <= 1'b1;
		cmd({OP_ENTER_QPI, 24'h0}, 8, 0);
		qm = 1'b1;
		chk(qpi, 24'h1);
		chk(dummy, 24'h2);
		for (i = 0; i < 16; i++) begin
			k = i[3:0];
			cmd({OP_SET_READ_PARAM, 2'h0, k[3:2], 2'h0, k[1:0], 16'h0}, 16, 0);
			chk(pbyte, {16'h0, 2'h0, k[3:2], 2'h0, k[1:0]});
			chk(dummy, 24'h2 + 24'h2 * k[3:2]);
			chk(wrap, 24'h8 << k[1:0]);
		end
		cmd({OP_SET_READ_PARAM, 8'h11, 16'h0}, 16, 0);
		// Start two bytes before the end of a 16-byte window
		@(posedge clk_i);
		baddr <= 24'h12340E;
		bload <= 1'b1;
		@(posedge clk_i);
		bload <= 1'b0;
		bstep <= 1'b1;
		repeat (2) @(posedge clk_i);
		bstep <= 1'b0;
		#1;
		chk(bout, 24'h123400);
		$display("Test parameters done");
		cmd({OP_EXIT_QPI, 24'h0}, 8, 0);
		qm = 1'b0;
		chk(qpi, 24'h0);
		chk(wrap, 24'h10);
		chk(dummy, 24'h8);
		@(posedge clk_i);
		wset <= 1'b1;
		wfld <= 2'h2;
		@(posedge clk_i);
		wset <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk(wrap, 24'h20);
		cmd({OP_ENTER_QPI, 24'h0}, 8, 0);
		qm = 1'b1;
		chk(qpi, 24'h1);
		chk(wrap, 24'h20);
		cmd({OP_EXIT_QPI, 24'h0}, 8, 0);
		qm = 1'b0;
		chk(qpi, 24'h0);
		$display("Test modes done");
		cmd({OP_GLOBAL_UNLOCK, 24'h0}, 8, 0);
		rdlock(24'h050000, 8'h01);
		@(posedge clk_i);
		write_enable_latch <= 1'b1;
		cmd({OP_GLOBAL_UNLOCK, 24'h0}, 8, 0);
		rdlock(24'h05FFFF, 8'h00);
		chk(aprot, 24'h0);
		cmd({OP_LOCK, 24'h05ABCD}, 32, 0);
		rdlock(24'h050000, 8'h01);
		rdlock(24'h060000, 8'h00);
		chk(aprot, 24'h1);
		@(posedge clk_i);
		write_enable_latch <= 1'b0;
		cmd({OP_UNLOCK, 24'h050000}, 32, 0);
		rdlock(24'h050000, 8'h01);
		@(posedge clk_i);
		write_enable_latch <= 1'b1;
		cmd({OP_UNLOCK, 24'h050000}, 32, 0);
		rdlock(24'h050000, 8'h00);
		cmd({OP_GLOBAL_LOCK, 24'h0}, 8, 0);
		rdlock(24'h060000, 8'h01);
		@(posedge clk_i);
		write_protect_select <= 1'b0;
		hit <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(aprot, 24'h0);
		cmd({OP_ENTER_QPI, 24'h0}, 8, 0);
		qm = 1'b1;
		rdlock(24'h060000, 8'h01);
		cmd({OP_GLOBAL_UNLOCK, 24'h0}, 8, 0);
		rdlock(24'h060000, 8'h00);
		$display("Test locks done");
		@(posedge clk_i);
		dev_rst <= 1'b1;
		@(posedge clk_i);
		dev_rst <= 1'b0;
		qm = 1'b0;
		repeat (2) @(posedge clk_i);
		chk(pbyte, 24'h0);
		chk(wrap, 24'h8);
		chk(qpi, 24'h0);
		rdlock(24'h060000, 8'h01);
		$display("Test reset instruction done");
		report_and_stop;
	end
endmodule
